/* File: shared/fetch_core_pkg.sv */
// Shared constants and types for the two-stage fetch and execute core.
package fetch_core_pkg;
   localparam int PC_W   = 13;
   localparam int WORD_W = 14;
   localparam int DATA_W = 8;
   localparam int FILE_W = 7;
   localparam int PHASES_PER_CYCLE = 4;

   // Phase codes follow a Gray sequence around the instruction cycle.
   typedef enum logic [1:0] {
      PH_ONE   = 2'h0,
      PH_TWO   = 2'h1,
      PH_THREE = 2'h3,
      PH_FOUR  = 2'h2
   } phase_t;

   // Instruction word layout.
   localparam int JUMP_BIT  = 13;
   localparam int LIT_BIT   = 12;
   localparam int OP_HI     = 11;
   localparam int OP_LO     = 8;
   localparam int DEST_BIT  = 7;
   localparam int LIT_HI    = 7;
   localparam int FILE_HI   = 6;
   localparam int TARGET_HI = 12;

   typedef enum logic [3:0] {
      OP_NOP   = 4'h0,
      OP_MOVE  = 4'h1,
      OP_ADD   = 4'h2,
      OP_SUB   = 4'h3,
      OP_AND   = 4'h4,
      OP_IOR   = 4'h5,
      OP_XOR   = 4'h6,
      OP_RLF   = 4'h7,
      OP_RRF   = 4'h8,
      OP_COMF  = 4'h9,
      OP_INCF  = 4'hA,
      OP_DECF  = 4'hB,
      OP_CLR   = 4'hC,
      OP_STORE = 4'hD,
      OP_SWAP  = 4'hE,
      OP_RSVD  = 4'hF
   } alu_op_t;

   // Core registers seen in the data space.
   localparam logic [6:0] FILE_INDIRECT = 7'h00;
   localparam logic [6:0] FILE_PC_LOW   = 7'h02;
   localparam logic [6:0] FILE_STATUS   = 7'h03;
   localparam logic [6:0] FILE_INDEX    = 7'h04;

   localparam int ST_CARRY  = 0;
   localparam int ST_NIBBLE = 1;
   localparam int ST_ZERO   = 2;

   localparam logic [13:0] NOP_WORD     = 14'h0000;
   localparam logic [12:0] PC_RESET     = 13'h0000;
   localparam logic [7:0]  ACC_RESET    = 8'h00;
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   localparam logic [7:0]  INDEX_RESET  = 8'h00;
endpackage

/* File: rtl/two_stage_fetch_execute_core.sv */
// Four-phase sequencer, overlapped fetch and execute pipeline and ALU.
`timescale 1ns/100ps

module two_stage_fetch_execute_core (
   input  wire logic                             ref_clk_i,
   input  wire logic                             rst_n_i,
   output logic [fetch_core_pkg::PC_W-1:0]       prog_addr_o,
   output logic                                  prog_rd_o,
   input  wire logic [fetch_core_pkg::WORD_W-1:0] prog_data_i,
   output logic [fetch_core_pkg::FILE_W-1:0]     data_addr_o,
   output logic                                  data_rd_o,
   input  wire logic [fetch_core_pkg::DATA_W-1:0] data_rdata_i,
   output logic                                  data_wr_o,
   output logic [fetch_core_pkg::DATA_W-1:0]     data_wdata_o,
   output logic                                  phase_one_o,
   output logic                                  phase_two_o,
   output logic                                  phase_three_o,
   output logic                                  phase_four_o,
   output logic [fetch_core_pkg::WORD_W-1:0]     instr_o,
   output logic [fetch_core_pkg::DATA_W-1:0]     acc_o,
   output logic [fetch_core_pkg::DATA_W-1:0]     status_o
);
   import fetch_core_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   phase_t              phase;
   phase_t              next_phase;
   logic                ent_one;
   logic                ent_two;
   logic                ent_three;
   logic                ent_four;
   logic                first;
   logic                flush;
   logic [PC_W-1:0]     pc;
   logic [PC_W-1:0]     target;
   logic [WORD_W-1:0]   instr;
   logic [DATA_W-1:0]   acc;
   logic [DATA_W-1:0]   status;
   logic [DATA_W-1:0]   index;
   logic [DATA_W-1:0]   operand;
   logic                is_jump;
   logic                is_lit;
   logic                is_file;
   alu_op_t             op;
   logic                to_file;
   logic [FILE_W-1:0]   eff_addr;
   logic                eff_core;
   logic                cur_core;
   logic [DATA_W-1:0]   core_rd;
   logic                writes;
   logic [DATA_W-1:0]   res;
   logic                res_c;
   logic                res_dc;
   logic                upd_c;
   logic                upd_dc;
   logic                upd_z;
   logic [DATA_W:0]     sum9;
   logic [DATA_W:0]     dif9;
   logic [4:0]          nsum;
   logic [4:0]          ndif;
   logic [DATA_W-1:0]   next_status;

   ////////////////////////////////////////////////////////////////////////
   // Phase sequencer; each input clock period is one phase.
   // four phase divider
   always_comb begin
      unique case (phase)
         PH_ONE:   next_phase = PH_TWO;
         PH_TWO:   next_phase = PH_THREE;
         PH_THREE: next_phase = PH_FOUR;
         PH_FOUR:  next_phase = PH_ONE;
      endcase
   end
   assign ent_one   = (phase == PH_FOUR);
   assign ent_two   = (phase == PH_ONE);
   assign ent_three = (phase == PH_TWO);
   assign ent_four  = (phase == PH_THREE);

   // Reset parks the sequencer in phase four so the next edge opens a cycle.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase <= PH_FOUR;
      end else begin
         phase <= next_phase;
      end
   end
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_one_o   <= 1'b0;
         phase_two_o   <= 1'b0;
         phase_three_o <= 1'b0;
         phase_four_o  <= 1'b1;
      end else begin
         phase_one_o   <= (next_phase == PH_ONE);
         phase_two_o   <= (next_phase == PH_TWO);
         phase_three_o <= (next_phase == PH_THREE);
         phase_four_o  <= (next_phase == PH_FOUR);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch side: program counter and instruction latch.
   // counter advances
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc <= PC_RESET;
      end else if (ent_one && !first) begin
         if (flush) begin
            pc <= target;
         end else begin
            pc <= pc + PC_W'(1);
         end
      end
   end
   assign prog_addr_o = pc;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prog_rd_o <= 1'b0;
      end else begin
         prog_rd_o <= ent_four;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         first <= 1'b1;
      end else if (ent_one) begin
         first <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         instr <= NOP_WORD;
      end else if (ent_one) begin
         instr <= (first || flush) ? NOP_WORD : prog_data_i;
      end
   end
   assign instr_o = instr;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flush  <= 1'b0;
         target <= PC_RESET;
      end else if (ent_one) begin
         flush <= 1'b0;
      end else if (ent_four && is_jump) begin
         flush  <= 1'b1;
         target <= instr[TARGET_HI:0];
      end else if (ent_four && is_file && to_file && writes &&
                   data_addr_o == FILE_PC_LOW) begin
         flush  <= 1'b1;
         target <= {pc[PC_W-1:DATA_W], res};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decode of the latched word.
   assign is_jump = instr[JUMP_BIT];
   assign is_lit  = !instr[JUMP_BIT] && instr[LIT_BIT];
   assign is_file = !instr[JUMP_BIT] && !instr[LIT_BIT];
   assign op      = alu_op_t'(instr[OP_HI:OP_LO]);
   assign to_file = instr[DEST_BIT];
   assign writes  = (op != OP_NOP) && (op != OP_RSVD);

   assign eff_addr = (instr[FILE_HI:0] == FILE_INDIRECT) ?
                     index[FILE_W-1:0] : instr[FILE_HI:0];
   assign eff_core = (eff_addr == FILE_INDIRECT) ||
                     (eff_addr == FILE_PC_LOW) ||
                     (eff_addr == FILE_STATUS) ||
                     (eff_addr == FILE_INDEX);

   always_comb begin
      unique case (data_addr_o)
         FILE_PC_LOW: core_rd = pc[DATA_W-1:0];
         FILE_STATUS: core_rd = status;
         FILE_INDEX:  core_rd = index;
         default:     core_rd = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Data memory port.
   // operand read
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_addr_o <= FILE_INDIRECT;
         data_rd_o   <= 1'b0;
         cur_core    <= 1'b1;
      end else begin
         data_rd_o <= ent_two && is_file && !eff_core;
         if (ent_two) begin
            data_addr_o <= eff_addr;
            cur_core    <= eff_core;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         operand <= 8'h00;
      end else if (ent_three) begin
         if (is_lit) begin
            operand <= instr[LIT_HI:0];
         end else if (cur_core) begin
            operand <= core_rd;
         end else begin
            operand <= data_rdata_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_wr_o    <= 1'b0;
         data_wdata_o <= 8'h00;
      end else begin
         data_wr_o <= ent_four && is_file && to_file && writes &&
                      !cur_core;
         if (ent_four) begin
            data_wdata_o <= res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Arithmetic unit.
   // sums and borrows
   assign sum9 = {1'b0, operand} + {1'b0, acc};
   assign dif9 = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
   assign nsum = {1'b0, operand[3:0]} + {1'b0, acc[3:0]};
   assign ndif = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

   always_comb begin
      res    = operand;
      res_c  = status[ST_CARRY];
      res_dc = status[ST_NIBBLE];
      upd_c  = 1'b0;
      upd_dc = 1'b0;
      upd_z  = 1'b1;
      unique case (op)
         OP_ADD: begin
            res    = sum9[DATA_W-1:0];
            res_c  = sum9[DATA_W];
            res_dc = nsum[4];
            upd_c  = 1'b1;
            upd_dc = 1'b1;
         end
         OP_SUB: begin
            res    = dif9[DATA_W-1:0];
            res_c  = dif9[DATA_W];
            res_dc = ndif[4];
            upd_c  = 1'b1;
            upd_dc = 1'b1;
         end
         OP_AND:  res = operand & acc;
         OP_IOR:  res = operand | acc;
         OP_XOR:  res = operand ^ acc;
         OP_RLF: begin
            res   = {operand[DATA_W-2:0], status[ST_CARRY]};
            res_c = operand[DATA_W-1];
            upd_c = 1'b1;
            upd_z = 1'b0;
         end
         OP_RRF: begin
            res   = {status[ST_CARRY], operand[DATA_W-1:1]};
            res_c = operand[0];
            upd_c = 1'b1;
            upd_z = 1'b0;
         end
         OP_COMF: res = ~operand;
         OP_INCF: res = operand + 8'h01;
         OP_DECF: res = operand - 8'h01;
         OP_CLR:  res = 8'h00;
         OP_STORE: begin
            res   = acc;
            upd_z = 1'b0;
         end
         OP_SWAP: begin
            res   = {operand[3:0], operand[DATA_W-1:4]};
            upd_z = 1'b0;
         end
         OP_MOVE: res = operand;
         OP_NOP, OP_RSVD: upd_z = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Commit in phase four.
   // accumulator update
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc <= ACC_RESET;
      end else if (ent_four && !is_jump && writes &&
                   (is_lit || !to_file)) begin
         acc <= res;
      end
   end
   assign acc_o = acc;

   // A software write to status is overridden by flags the ALU sets.
   always_comb begin
      next_status = status;
      if (is_file && to_file && writes && data_addr_o == FILE_STATUS) begin
         next_status = res;
      end
      if (upd_c) begin
         next_status[ST_CARRY] = res_c;
      end
      if (upd_dc) begin
         next_status[ST_NIBBLE] = res_dc;
      end
      if (upd_z) begin
         next_status[ST_ZERO] = (res == 8'h00);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status <= STATUS_RESET;
      end else if (ent_four && !is_jump) begin
         status <= next_status;
      end
   end
   assign status_o = status;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         index <= INDEX_RESET;
      end else if (ent_four && is_file && to_file && writes &&
                   data_addr_o == FILE_INDEX) begin
         index <= res;
      end
   end

endmodule // two_stage_fetch_execute_core

/* File: verif/fetch_core_mem_model.sv */
// Program and data memory model facing the core's memory ports.
`timescale 1ns/100ps
module fetch_core_mem_model (
   input  wire logic                              clk_i,
   input  wire logic [fetch_core_pkg::PC_W-1:0]   prog_addr_i,
   input  wire logic                              prog_rd_i,
   output logic      [fetch_core_pkg::WORD_W-1:0] prog_data_o,
   input  wire logic [fetch_core_pkg::FILE_W-1:0] data_addr_i,
   input  wire logic                              data_rd_i,
   output logic      [fetch_core_pkg::DATA_W-1:0] data_rdata_o,
   input  wire logic                              data_wr_i,
   input  wire logic [fetch_core_pkg::DATA_W-1:0] data_wdata_i
);
   import fetch_core_pkg::*;
   logic [WORD_W-1:0] rom [0:(1<<PC_W)-1];
   logic [DATA_W-1:0] ram [0:(1<<FILE_W)-1];
   logic              churn = 1'b0;

   // Outside a strobe the buses toggle so stale data is never trusted.
   always @(posedge clk_i) begin
      churn <= ~churn;
   end
   // one whole word per fetch strobe
   assign prog_data_o = prog_rd_i ? rom[prog_addr_i] : {WORD_W{churn}};
   assign data_rdata_o = data_rd_i ? ram[data_addr_i] : {DATA_W{churn}};
   always @(posedge clk_i) begin
      if (data_wr_i) begin
         ram[data_addr_i] <= data_wdata_i;
      end
   end
   initial begin
      foreach (rom[i]) rom[i] = NOP_WORD;
      foreach (ram[i]) ram[i] = 8'h00;
   end
endmodule // fetch_core_mem_model

/* File: verif/two_stage_fetch_execute_core_chk.sv */
// Timing checker for the two-stage fetch and execute core.
`timescale 1ns/100ps
module two_stage_fetch_execute_core_chk (
   input wire logic                              ref_clk_i,
   input wire logic                              rst_n_i,
   input wire logic [fetch_core_pkg::PC_W-1:0]   prog_addr_o,
   input wire logic                              prog_rd_o,
   input wire logic                              data_rd_o,
   input wire logic                              data_wr_o,
   input wire logic                              phase_one_o,
   input wire logic                              phase_two_o,
   input wire logic                              phase_three_o,
   input wire logic                              phase_four_o,
   input wire logic [fetch_core_pkg::WORD_W-1:0] instr_o
);
   import fetch_core_pkg::*;
   logic [WORD_W-1:0] instr_q;
   logic [PC_W-1:0]   pc_q;
   logic              rd_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         instr_q <= NOP_WORD;
         pc_q    <= PC_RESET;
         rd_q    <= 1'b0;
      end else begin
         instr_q <= instr_o;
         pc_q    <= prog_addr_o;
         rd_q    <= prog_rd_o;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   phase_one_hot_a: assert property (
      $onehot({phase_one_o, phase_two_o, phase_three_o, phase_four_o}))
      else $error("phase outputs not one-hot");
   phase_order_a: assert property (
      phase_one_o |=> phase_two_o ##1 phase_three_o ##1 phase_four_o
      ##1 phase_one_o) else $error("phase order broken");
   pc_hold_a: assert property (
      !phase_one_o |-> $stable(prog_addr_o))
      else $error("program address moved outside phase one");
   fetch_phase_a: assert property (
      prog_rd_o |-> phase_four_o) else $error("fetch outside phase four");
   fetch_each_a: assert property (
      phase_one_o |-> ##3 prog_rd_o) else $error("fetch missing in cycle");
   latch_hold_a: assert property (
      !phase_one_o |-> $stable(instr_o))
      else $error("instruction latch moved mid-cycle");
   operand_rd_a: assert property (
      data_rd_o |-> phase_two_o) else $error("operand read off phase two");
   dest_wr_a: assert property (
      data_wr_o |-> phase_four_o) else $error("write off phase four");
   pc_step_a: assert property (
      phase_one_o && rd_q && instr_q[13:12] == 2'b01
      |-> prog_addr_o == pc_q + 13'h0001) else $error("pc did not step");
   jump_flush_a: assert property (
      phase_one_o && rd_q && instr_q[JUMP_BIT]
      |-> prog_addr_o == instr_q[TARGET_HI:0] && instr_o == NOP_WORD)
      else $error("jump target or flush wrong");

   jump_seen_c: cover property (phase_one_o && rd_q && instr_q[JUMP_BIT]);
   write_seen_c: cover property (data_wr_o);
   read_seen_c: cover property (data_rd_o);
endmodule // two_stage_fetch_execute_core_chk

bind two_stage_fetch_execute_core two_stage_fetch_execute_core_chk u_chk (
   .ref_clk_i, .rst_n_i, .prog_addr_o, .prog_rd_o, .data_rd_o, .data_wr_o,
   .phase_one_o, .phase_two_o, .phase_three_o, .phase_four_o, .instr_o);

/* File: verif/test_two_stage_fetch_execute_core.sv */
// Self-checking bench for the two-stage fetch and execute core.
`timescale 1ns/100ps
module test_two_stage_fetch_execute_core;
   import fetch_core_pkg::*;
   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic [DATA_W-1:0] acc;
      logic [DATA_W-1:0] st;
   } row_t;
   localparam int              N_ROWS = 24;
   localparam logic [PC_W-1:0] TARGET = 13'h0040;
   localparam row_t ROWS [N_ROWS] = '{
      '{14'h110F, 8'h0F, 8'h00}, '{14'h1201, 8'h10, 8'h02},
      '{14'h1310, 8'h00, 8'h07}, '{14'h1581, 8'h81, 8'h03},
      '{14'h1300, 8'h7F, 8'h00}, '{14'h140F, 8'h0F, 8'h00},
      '{14'h160F, 8'h00, 8'h04}, '{14'h1180, 8'h80, 8'h00},
      '{14'h1280, 8'h00, 8'h05}, '{14'h0DA0, 8'h00, 8'h05},
      '{14'h0720, 8'h01, 8'h04}, '{14'h0AA0, 8'h01, 8'h00},
      '{14'h0920, 8'hFE, 8'h00}, '{14'h0820, 8'h00, 8'h01},
      '{14'h1122, 8'h22, 8'h01}, '{14'h0D84, 8'h22, 8'h01},
      '{14'h0D80, 8'h22, 8'h01}, '{14'h0B00, 8'h21, 8'h01},
      '{14'h1E3C, 8'hC3, 8'h01}, '{14'h0C00, 8'h00, 8'h05},
      '{14'h1102, 8'h02, 8'h01}, '{14'h0D83, 8'h02, 8'h02},
      '{14'h1F55, 8'h02, 8'h02}, '{14'h0A03, 8'h03, 8'h02}};
   logic              ref_clk_i;
   logic              rst_n_i;
   logic [PC_W-1:0]   prog_addr;
   logic              prog_rd;
   logic [WORD_W-1:0] prog_data;
   logic [FILE_W-1:0] data_addr;
   logic              data_rd;
   logic [DATA_W-1:0] data_rdata;
   logic              data_wr;
   logic [DATA_W-1:0] data_wdata;
   logic [3:0]        phase;
   logic [WORD_W-1:0] instr;
   logic [DATA_W-1:0] acc;
   logic [DATA_W-1:0] status;
   int                n_mismatch = 0;
   int                tests_run = 0;

   two_stage_fetch_execute_core u_two_stage_fetch_execute_core (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .prog_addr_o(prog_addr),
      .prog_rd_o(prog_rd), .prog_data_i(prog_data), .data_addr_o(data_addr),
      .data_rd_o(data_rd), .data_rdata_i(data_rdata), .data_wr_o(data_wr),
      .data_wdata_o(data_wdata), .phase_one_o(phase[0]),
      .phase_two_o(phase[1]), .phase_three_o(phase[2]),
      .phase_four_o(phase[3]), .instr_o(instr), .acc_o(acc),
      .status_o(status));
   fetch_core_mem_model u_fetch_core_mem_model (
      .clk_i(ref_clk_i), .prog_addr_i(prog_addr), .prog_rd_i(prog_rd),
      .prog_data_o(prog_data), .data_addr_i(data_addr), .data_rd_i(data_rd),
      .data_rdata_o(data_rdata), .data_wr_i(data_wr),
      .data_wdata_i(data_wdata));

   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [WORD_W-1:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_byte(input logic [DATA_W-1:0] got, exp);
      chk_word({6'h00, got}, {6'h00, exp});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // Waits up to 16 clocks for a word to reach the instruction latch.
   task automatic wait_word(input logic [WORD_W-1:0] w);
      int k;
      k = 0;
      while (instr !== w && k < 16) begin
         step(1);
         k++;
      end
      if (instr !== w) begin
         n_mismatch++;
         end_of_test();
      end
   endtask

   initial begin
      rst_n_i = 1'b0;
      #1;
      for (int i = 0; i < N_ROWS; i++) begin
         u_fetch_core_mem_model.rom[i] = ROWS[i].word;
      end
      u_fetch_core_mem_model.rom[N_ROWS] = {1'b1, TARGET};
      u_fetch_core_mem_model.rom[N_ROWS+1] = 14'h11EE;
      u_fetch_core_mem_model.rom[TARGET] = 14'h115A;
      u_fetch_core_mem_model.rom[TARGET+1] = 14'h0D82;
      u_fetch_core_mem_model.rom[TARGET+2] = 14'h11EE;
      u_fetch_core_mem_model.rom[13'h005A] = 14'h1133;
      step(10);
      chk_byte({4'h0, phase}, 8'h08);
      chk_word({1'b0, prog_addr}, 14'h0000);
      chk_word(instr, NOP_WORD);
      chk_byte(acc, ACC_RESET);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      step(3);
      chk_byte({7'h00, prog_rd}, 8'h00);
      step(1);
      chk_byte({7'h00, prog_rd}, 8'h01);
      chk_word(instr, NOP_WORD);
      for (int i = 0; i < N_ROWS; i++) begin
         wait_word(ROWS[i].word);
         step(4);
         chk_byte(acc, ROWS[i].acc);
         chk_byte(status, ROWS[i].st);
         chk_word({1'b0, prog_addr}, 14'(i + 2));
      end
      chk_byte(u_fetch_core_mem_model.ram[32], 8'h01);
      chk_byte(u_fetch_core_mem_model.ram[34], 8'h22);
      wait_word({1'b1, TARGET});
      step(4);
      chk_word(instr, NOP_WORD);
      chk_word({1'b0, prog_addr}, {1'b0, TARGET});
      step(4);
      chk_word(instr, 14'h115A);
      chk_byte(acc, 8'h03);
      step(4);
      chk_byte(acc, 8'h5A);
      step(4);
      chk_word(instr, NOP_WORD);
      chk_word({1'b0, prog_addr}, 14'h005A);
      step(4);
      chk_word(instr, 14'h1133);
      chk_byte(acc, 8'h5A);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      #1;
      chk_word({1'b0, prog_addr}, 14'h0000);
      chk_byte(acc, ACC_RESET);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      wait_word(ROWS[0].word);
      step(4);
      chk_byte(acc, ROWS[0].acc);
      end_of_test();
   end
endmodule // test_two_stage_fetch_execute_core
